// ### design/bus_transfer_panel_control.sv
// Supervisory control for a two-way static transfer unit: mode, preferred source,
// automatic transfer timing, diagnostics, indicators, alarm and transfer counter.
// Assumes source quality comparisons arrive as digital flags from the monitoring
// front end; panel and GUI inputs are asynchronous and get synchronised here.
`timescale 1ns/10ps
module bus_transfer_panel_control
  import transfer_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_CYC,
  parameter int unsigned LAMP_TEST_CYCLES = LAMP_TEST_CYC,
  parameter int unsigned SEC_CYCLES       = SEC_CYC,
  parameter int unsigned XFER_CYCLES      = XFER_MAX_CYC
)(
  // Clock, reset, enable
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic               i_ce,
  // Panel switches
  input  wire logic               i_pnl_auto,
  input  wire logic               i_pnl_pref_alt,
  input  wire logic               i_pnl_lamp_test,
  input  wire logic               i_pnl_ctrl_en,
  input  wire logic               i_pnl_manual,
  input  wire logic               i_pnl_xfer_test,
  input  wire logic               i_pnl_fault_reset,
  input  wire logic               i_pnl_alarm_ack,
  // GUI equivalents
  input  wire logic               i_gui_auto,
  input  wire logic               i_gui_override,
  input  wire logic               i_gui_lamp_test,
  input  wire logic               i_gui_ctrl_en,
  input  wire logic               i_gui_manual,
  input  wire logic               i_gui_xfer_test,
  input  wire logic               i_gui_fault_reset,
  // Configuration
  input  wire logic [6:0]         i_cfg_pickup_pct,
  input  wire logic [3:0]         i_cfg_stab_s,
  input  wire logic [1:0]         i_cfg_uf_hz,
  input  wire logic               i_cfg_freq_trip_en,
  input  wire logic               i_cfg_alarm_dis,
  input  wire logic               i_cfg_air_cooled,
  // Source monitoring flags
  input  wire logic               i_norm_ok,
  input  wire logic               i_alt_ok,
  input  wire logic               i_norm_uf,
  input  wire logic               i_alt_uf,
  input  wire logic               i_out_of_phase,
  input  wire logic [1:0]         i_air_loss,
  // Diagnostics
  input  wire logic [FAULT_W-1:0] i_diag_fault,
  input  wire logic               i_sw_fail_norm,
  input  wire logic               i_sw_fail_alt,
  // Switch drivers
  output logic                    o_drv_norm,
  output logic                    o_drv_alt,
  // Indicators
  output logic                    o_lamp_load,
  output logic                    o_lamp_norm,
  output logic                    o_lamp_alt,
  output logic                    o_lamp_auto,
  output logic                    o_lamp_manual,
  output logic                    o_lamp_fault,
  output logic                    o_lamp_pref_norm,
  output logic                    o_lamp_pref_alt,
  output logic                    o_lamp_phase,
  output logic                    o_lamp_air_part,
  output logic                    o_lamp_air_full,
  output logic                    o_alarm,
  output logic                    o_disp_fault,
  output logic [COUNT_W-1:0]      o_display,
  output logic [6:0]              o_pickup_pct,
  output logic                    o_xfer_busy
);

  // Two-flop synchronisers for every asynchronous pin
  localparam int unsigned NSYNC = 16 + FAULT_W;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else if (i_ce)
    begin
      sync_a <= {i_diag_fault, i_air_loss, i_out_of_phase, i_alt_uf, i_norm_uf, i_alt_ok,
                 i_norm_ok, i_sw_fail_alt, i_sw_fail_norm, i_pnl_alarm_ack,
                 i_pnl_auto, i_pnl_pref_alt, i_pnl_lamp_test | i_gui_lamp_test,
                 i_pnl_ctrl_en | i_gui_ctrl_en, i_pnl_manual | i_gui_manual,
                 i_pnl_xfer_test | i_gui_xfer_test};
      sync_b <= sync_a;
    end
  end
  logic [FAULT_W-1:0] diag;
  logic [1:0] air;
  logic phase, alt_uf, norm_uf, alt_ok, norm_ok, fail_alt, fail_norm, ack;
  logic pnl_auto, pref_alt;
  logic lamp_s, en_s, manual_s, test_s;
  logic [NBTN-1:0] raw_btn;
  assign {diag, air, phase, alt_uf, norm_uf, alt_ok, norm_ok, fail_alt, fail_norm, ack,
          pnl_auto, pref_alt, lamp_s, en_s, manual_s, test_s} = sync_b;
  // Fault reset and GUI mode synchronised separately to keep the packed group readable
  logic rst_a, rst_b;
  logic [1:0] gui_mode_a, gui_mode_b;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      rst_a <= 1'b0;
      rst_b <= 1'b0;
      gui_mode_a <= '0;
      gui_mode_b <= '0;
    end
    else if (i_ce)
    begin
      rst_a <= i_pnl_fault_reset | i_gui_fault_reset;
      rst_b <= rst_a;
      gui_mode_a <= {i_gui_override, i_gui_auto};
      gui_mode_b <= gui_mode_a;
    end
  end
  always_comb
  begin
    raw_btn             = '0;
    raw_btn[BTN_LAMP]   = lamp_s;
    raw_btn[BTN_ENABLE] = en_s;
    raw_btn[BTN_MANUAL] = manual_s;
    raw_btn[BTN_TEST]   = test_s;
    raw_btn[BTN_RESET]  = rst_b;
  end

  // Debounce: a button state is accepted after it stays stable for the full count
  logic [NBTN-1:0] btn;
  logic [NBTN-1:0] btn_q;
  logic [31:0]     db_cnt [NBTN];
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      btn   <= '0;
      btn_q <= '0;
      for (int i = 0; i < NBTN; i++) db_cnt[i] <= '0;
    end
    else if (i_ce)
    begin
      btn_q <= btn;
      for (int i = 0; i < NBTN; i++)
      begin
        if (raw_btn[i] == btn[i])
          db_cnt[i] <= '0;
        else if (db_cnt[i] >= DEBOUNCE_CYCLES - 1)
        begin
          btn[i]    <= raw_btn[i];
          db_cnt[i] <= '0;
        end
        else
          db_cnt[i] <= db_cnt[i] + 32'h1;
      end
    end
  end
  logic [NBTN-1:0] press;
  assign press = btn & ~btn_q;
  logic en_held;
  assign en_held = btn[BTN_ENABLE];
  logic manual_req, test_req, reset_req;
  assign manual_req = press[BTN_MANUAL] & en_held;
  assign test_req   = press[BTN_TEST] & en_held;
  assign reset_req  = press[BTN_RESET] & en_held;

  // Mode and preferred source; GUI can override the mode selector position only, not the preferred source
  logic auto_mode, pref_src;
  assign auto_mode = gui_mode_b[1] ? gui_mode_b[0] : pnl_auto;
  assign pref_src  = pref_alt ? SRC_ALTERNATE : SRC_NORMAL;
  assign o_pickup_pct = (i_cfg_pickup_pct < PICKUP_MIN_PCT) ? PICKUP_MIN_PCT :
                        (i_cfg_pickup_pct > PICKUP_MAX_PCT) ? PICKUP_MAX_PCT :
                        i_cfg_pickup_pct;

  // Source availability; frequency trip applies only when configured
  logic freq_ok_n, freq_ok_a, avail_n, avail_a;
  assign freq_ok_n = !(i_cfg_freq_trip_en && i_cfg_uf_hz >= UF_MIN_HZ && norm_uf);
  assign freq_ok_a = !(i_cfg_freq_trip_en && i_cfg_uf_hz >= UF_MIN_HZ && alt_uf);
  assign avail_n = norm_ok & freq_ok_n;
  assign avail_a = alt_ok & freq_ok_a;

  // Transfer sequencer
  xfer_state_t state;
  logic        active;
  logic        target;
  logic [31:0] xcnt;
  logic [31:0] stab_cnt;
  logic [3:0]  stab_s;
  logic        stab_done;
  assign stab_s    = (i_cfg_stab_s > STAB_MAX_S) ? STAB_MAX_S : i_cfg_stab_s;
  assign stab_done = stab_cnt == 32'h0;
  logic active_avail, other_avail, want_auto, auto_target;
  assign active_avail = (active == SRC_NORMAL) ? avail_n : avail_a;
  assign other_avail  = (active == SRC_NORMAL) ? avail_a : avail_n;
  // Loss of active source transfers at once; return to preferred waits for stability
  always_comb
  begin
    want_auto   = 1'b0;
    auto_target = ~active;
    if (!active_avail && other_avail)
      want_auto = 1'b1;
    else if (active != pref_src && ((pref_src == SRC_NORMAL) ? avail_n : avail_a) &&
             stab_done)
      want_auto = 1'b1;
  end
  logic fail_req, fail_target;
  assign fail_req    = (fail_norm && active != SRC_NORMAL) ||
                       (fail_alt && active != SRC_ALTERNATE);
  assign fail_target = fail_norm ? SRC_NORMAL : SRC_ALTERNATE;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state  <= ST_IDLE;
      active <= SRC_NORMAL;
      target <= SRC_NORMAL;
      xcnt   <= '0;
    end
    else if (i_ce)
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (fail_req)
          begin
            target <= fail_target;
            state  <= ST_SWITCH;
          end
          else if (manual_req && !auto_mode)
          begin
            target <= ~active;
            state  <= ST_SWITCH;
          end
          else if (test_req && other_avail)
          begin
            target <= ~active;
            state  <= ST_SWITCH;
          end
          // Never leave a side with a failed element, or the two rules would ping-pong
          else if (auto_mode && want_auto && !fail_norm && !fail_alt)
          begin
            target <= auto_target;
            state  <= ST_SWITCH;
          end
          xcnt <= '0;
        end
        ST_SWITCH:
        begin
          // Break-before-make in one cycle, far inside the half-cycle limit
          active <= target;
          xcnt   <= 32'h1;
          state  <= ST_HOLD;
        end
        ST_HOLD:
        begin
          // Gate drive settles before a new transfer may start
          if (xcnt >= XFER_CYCLES - 1)
            state <= ST_IDLE;
          else
            xcnt <= xcnt + 32'h1;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
  assign o_xfer_busy = state != ST_IDLE;

  // Stabilization timer restarts whenever the preferred source is not available
  logic [31:0] sec_cnt;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      stab_cnt <= '0;
      sec_cnt  <= '0;
    end
    else if (i_ce)
    begin
      if (!((pref_src == SRC_NORMAL) ? avail_n : avail_a) || active == pref_src)
      begin
        stab_cnt <= 32'(stab_s);
        sec_cnt  <= '0;
      end
      else if (!stab_done)
      begin
        if (sec_cnt >= SEC_CYCLES - 1)
        begin
          sec_cnt  <= '0;
          stab_cnt <= stab_cnt - 32'h1;
        end
        else
          sec_cnt <= sec_cnt + 32'h1;
      end
    end
  end

  // Drivers follow the active source, both off during the switch cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_drv_norm <= 1'b0;
      o_drv_alt  <= 1'b0;
    end
    else if (i_ce)
    begin
      o_drv_norm <= (state != ST_SWITCH) && active == SRC_NORMAL;
      o_drv_alt  <= (state != ST_SWITCH) && active == SRC_ALTERNATE;
    end
  end

  // Fault latching: diagnostic faults that persist two samples latch until reset; blocking faults follow live
  logic [FAULT_W-1:0] fault_lat;
  logic [FAULT_W-1:0] fault_prev;
  logic [FAULT_W-1:0] fault_ack;
  logic               alarm_on;
  logic any_fault;
  assign any_fault = (|fault_lat) | (|diag) | fail_norm | fail_alt;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      fault_lat  <= '0;
      fault_prev <= '0;
    end
    else if (i_ce)
    begin
      fault_prev <= diag;
      // A fault still present is re-set in the reset cycle, so reset cannot hide it
      if (reset_req)
        fault_lat <= diag;
      else
        fault_lat <= fault_lat | (diag & fault_prev);
    end
  end
  // Alarm sounds only for faults that persist two samples; ack silences current ones
  logic [FAULT_W-1:0] persist;
  assign persist = diag & fault_prev;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      fault_ack <= '0;
      alarm_on  <= 1'b0;
    end
    else if (i_ce)
    begin
      if (ack)
        fault_ack <= persist;
      else
        fault_ack <= fault_ack & persist;
      alarm_on <= !i_cfg_alarm_dis && |(persist & ~fault_ack & ~({FAULT_W{ack}}));
    end
  end

  // Transfer counter
  logic [COUNT_W-1:0] xfer_count;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      xfer_count <= '0;
    else if (i_ce && state == ST_SWITCH && target != active)
      xfer_count <= xfer_count + 1'b1;
  end

  // Lamp test timer
  logic [31:0] lamp_cnt;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      lamp_cnt <= '0;
    else if (i_ce)
    begin
      if (press[BTN_LAMP])
        lamp_cnt <= 32'(LAMP_TEST_CYCLES);
      else if (lamp_cnt != 32'h0)
        lamp_cnt <= lamp_cnt - 32'h1;
    end
  end
  logic lt;
  assign lt = lamp_cnt != 32'h0;

  // Indicators; lamp test touches only lamps, never the drivers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_lamp_load      <= 1'b0;
      o_lamp_norm      <= 1'b0;
      o_lamp_alt       <= 1'b0;
      o_lamp_auto      <= 1'b0;
      o_lamp_manual    <= 1'b0;
      o_lamp_fault     <= 1'b0;
      o_lamp_pref_norm <= 1'b0;
      o_lamp_pref_alt  <= 1'b0;
      o_lamp_phase     <= 1'b0;
      o_lamp_air_part  <= 1'b0;
      o_lamp_air_full  <= 1'b0;
      o_alarm          <= 1'b0;
      o_disp_fault     <= 1'b0;
      o_display        <= '0;
    end
    else if (i_ce)
    begin
      o_lamp_load      <= lt | ((active == SRC_NORMAL) ? avail_n : avail_a);
      o_lamp_norm      <= lt | avail_n;
      o_lamp_alt       <= lt | avail_a;
      o_lamp_auto      <= lt | auto_mode;
      o_lamp_manual    <= lt | !auto_mode;
      o_lamp_fault     <= lt | any_fault;
      o_lamp_pref_norm <= lt | (pref_src == SRC_NORMAL);
      o_lamp_pref_alt  <= lt | (pref_src == SRC_ALTERNATE);
      o_lamp_phase     <= lt | phase;
      o_lamp_air_part  <= lt | (i_cfg_air_cooled & air[0]);
      o_lamp_air_full  <= lt | (i_cfg_air_cooled & air[1]);
      o_alarm          <= alarm_on;
      // Out-of-phase deliberately excluded from the fault display
      o_disp_fault     <= any_fault;
      o_display        <= any_fault ? COUNT_W'(fault_lat | diag) : xfer_count;
    end
  end

endmodule : bus_transfer_panel_control

// ### inc/transfer_pkg.sv
// Constants shared by the transfer panel controller.
// Assumes a 50 MHz system clock.
package transfer_pkg;
  localparam int unsigned CLK_HZ          = 50000000;
  // Pickup threshold setting range, percent of rated voltage
  localparam logic [6:0]  PICKUP_MIN_PCT  = 7'h55;
  localparam logic [6:0]  PICKUP_MAX_PCT  = 7'h5f;
  // Re-transfer stabilization delay range, seconds
  localparam logic [3:0]  STAB_MAX_S      = 4'ha;
  // Under-frequency trigger range, Hz below rated
  localparam logic [1:0]  UF_MIN_HZ       = 2'h2;
  localparam logic [1:0]  UF_MAX_HZ       = 2'h3;
  // Debounce time for panel pushbuttons
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
  // Indicator lamp test duration
  localparam int unsigned LAMP_TEST_MS    = 2000;
  localparam int unsigned LAMP_TEST_CYC   = CLK_HZ / 1000 * LAMP_TEST_MS;
  // Transfer completion window, quarter to half line cycle, in microseconds (60 Hz)
  localparam int unsigned XFER_MIN_US     = 4167;
  localparam int unsigned XFER_MAX_US     = 8333;
  localparam int unsigned XFER_MAX_CYC    = CLK_HZ / 1000000 * XFER_MAX_US;
  // Cycles per second, for the stabilization delay
  localparam int unsigned SEC_CYC         = CLK_HZ;
  // Number of pushbutton inputs
  localparam int unsigned NBTN            = 5;
  localparam int unsigned BTN_LAMP        = 0;
  localparam int unsigned BTN_ENABLE      = 1;
  localparam int unsigned BTN_MANUAL      = 2;
  localparam int unsigned BTN_TEST        = 3;
  localparam int unsigned BTN_RESET       = 4;
  localparam logic        SRC_NORMAL      = 1'b0;
  localparam logic        SRC_ALTERNATE   = 1'b1;
  localparam int unsigned FAULT_W         = 8;
  localparam int unsigned COUNT_W         = 16;
  typedef enum logic [1:0] {ST_IDLE, ST_SWITCH, ST_HOLD} xfer_state_t;
endpackage : transfer_pkg

// ### tb/bus_transfer_panel_monitor.sv
// Port-level concurrent checks for the transfer panel controller.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
module bus_transfer_panel_monitor
  import transfer_pkg::*;
#(
  parameter int unsigned XFER_CYCLES = XFER_MAX_CYC
)(
  // Clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  // Watched inputs
  input  wire logic               i_pnl_auto,
  input  wire logic               i_gui_override,
  input  wire logic [6:0]         i_cfg_pickup_pct,
  input  wire logic               i_cfg_alarm_dis,
  input  wire logic               i_cfg_air_cooled,
  input  wire logic               i_out_of_phase,
  input  wire logic [1:0]         i_air_loss,
  input  wire logic [FAULT_W-1:0] i_diag_fault,
  input  wire logic               i_sw_fail_norm,
  input  wire logic               i_sw_fail_alt,
  // Watched outputs
  input  wire logic               o_drv_norm,
  input  wire logic               o_drv_alt,
  input  wire logic               o_lamp_auto,
  input  wire logic               o_lamp_fault,
  input  wire logic               o_lamp_phase,
  input  wire logic               o_lamp_air_full,
  input  wire logic               o_alarm,
  input  wire logic [6:0]         o_pickup_pct,
  input  wire logic               o_xfer_busy
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  property p_no_overlap;
    !(o_drv_norm && o_drv_alt);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both switch drivers on");
  property p_pickup;
    (i_cfg_pickup_pct >= PICKUP_MIN_PCT && i_cfg_pickup_pct <= PICKUP_MAX_PCT)
      |-> o_pickup_pct == i_cfg_pickup_pct;
  endproperty
  a_pickup: assert property (p_pickup)
    else $error("pickup setting altered inside range");
  property p_xfer_done;
    $rose(o_xfer_busy) |-> ##[1:2] (!o_drv_norm && !o_drv_alt) ##1 (o_drv_norm ^ o_drv_alt);
  endproperty
  a_xfer_done: assert property (p_xfer_done)
    else $error("transfer did not complete in time");
  property p_busy_len;
    (XFER_CYCLES >= 4) && $rose(o_xfer_busy) |-> o_xfer_busy[*4];
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy dropped early");
  property p_fault_lamp;
    (i_diag_fault != '0)[*4] |=> o_lamp_fault;
  endproperty
  a_fault_lamp: assert property (p_fault_lamp)
    else $error("fault lamp off while fault present");
  property p_alarm_dis;
    i_cfg_alarm_dis[*4] |=> !o_alarm;
  endproperty
  a_alarm_dis: assert property (p_alarm_dis)
    else $error("alarm sounded while disabled");
  property p_mode_lamp;
    (i_pnl_auto && !i_gui_override)[*4] |=> o_lamp_auto;
  endproperty
  a_mode_lamp: assert property (p_mode_lamp)
    else $error("auto lamp off in auto mode");
  property p_phase;
    i_out_of_phase[*4] |=> o_lamp_phase;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase lamp off");
  property p_air;
    (i_cfg_air_cooled && i_air_loss[1])[*4] |=> o_lamp_air_full;
  endproperty
  a_air: assert property (p_air)
    else $error("air loss lamp off");
  property p_sw_fail;
    (i_sw_fail_alt && !i_sw_fail_norm)[*4] |-> ##[0:20] o_drv_alt;
  endproperty
  a_sw_fail: assert property (p_sw_fail)
    else $error("no transfer to failed side");

  c_manual: cover property ($rose(o_xfer_busy) && !i_pnl_auto);
  c_alarm: cover property ($rose(o_alarm));
  c_lamp_test: cover property (o_lamp_auto && o_lamp_fault && o_lamp_phase);
endmodule : bus_transfer_panel_monitor

bind bus_transfer_panel_control bus_transfer_panel_monitor #(.XFER_CYCLES(XFER_CYCLES)) u_mon (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pnl_auto(i_pnl_auto),
  .i_gui_override(i_gui_override), .i_cfg_pickup_pct(i_cfg_pickup_pct),
  .i_cfg_alarm_dis(i_cfg_alarm_dis), .i_cfg_air_cooled(i_cfg_air_cooled),
  .i_out_of_phase(i_out_of_phase), .i_air_loss(i_air_loss), .i_diag_fault(i_diag_fault),
  .i_sw_fail_norm(i_sw_fail_norm), .i_sw_fail_alt(i_sw_fail_alt), .o_drv_norm(o_drv_norm),
  .o_drv_alt(o_drv_alt), .o_lamp_auto(o_lamp_auto), .o_lamp_fault(o_lamp_fault),
  .o_lamp_phase(o_lamp_phase), .o_lamp_air_full(o_lamp_air_full), .o_alarm(o_alarm),
  .o_pickup_pct(o_pickup_pct), .o_xfer_busy(o_xfer_busy));

// ### tb/panel_model.sv
// Operator panel and GUI pushbutton model.
// Assumes buttons are sampled on rising clock edges; changes at falling edges.
`timescale 1ns/10ps
module panel_model
  import transfer_pkg::*;
#(
  parameter int unsigned HOLD = 12
)(
  // Clock
  input  wire logic            i_clk_sys,
  // Buttons
  output logic [NBTN-1:0]      o_pnl,
  output logic [NBTN-1:0]      o_gui
);
  initial
  begin
    o_pnl = '0;
    o_gui = '0;
  end

  // Held well past debounce, then released: a momentary press, never a level
  task automatic push(input logic gui, input logic [NBTN-1:0] btn);
    @(negedge i_clk_sys);
    if (gui)
      o_gui = btn;
    else
      o_pnl = btn;
    repeat (HOLD) @(negedge i_clk_sys);
    o_pnl = '0;
    o_gui = '0;
    repeat (HOLD) @(negedge i_clk_sys);
  endtask : push
endmodule : panel_model

// ### tb/test_bus_transfer_panel_control.sv
// Self-checking bench for the transfer panel controller.
// Assumes debounce 4, lamp test 20, one second 10 and busy 8 cycles.
`timescale 1ns/10ps
module test_bus_transfer_panel_control
  import transfer_pkg::*;
;
  logic clk, rst, auto, pref_alt, ack, ovr, gui_auto, alarm_dis, norm_ok, alt_ok, norm_uf;
  logic oop, fail_alt, drv_n, drv_a, alarm, disp_fault, busy;
  logic ce, trip_en, air_cooled, alt_uf, fail_norm;
  logic [3:0] stab;
  logic [6:0] pickup, pick_o;
  logic [1:0] air, uf_hz;
  logic [7:0] diag;
  logic [10:0] lamps;
  logic [15:0] display, cnt;
  logic [NBTN-1:0] pnl, gui;
  logic [6:0] corner [4] = '{7'h54, 7'h55, 7'h5f, 7'h60};
  integer seed, num_errors, checks;

  panel_model pm (.i_clk_sys(clk), .o_pnl(pnl), .o_gui(gui));
  bus_transfer_panel_control #(.DEBOUNCE_CYCLES(4), .LAMP_TEST_CYCLES(20), .SEC_CYCLES(10),
    .XFER_CYCLES(8)) dut (
    .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_pnl_auto(auto), .i_pnl_pref_alt(pref_alt),
    .i_pnl_lamp_test(pnl[0]), .i_pnl_ctrl_en(pnl[1]), .i_pnl_manual(pnl[2]),
    .i_pnl_xfer_test(pnl[3]), .i_pnl_fault_reset(pnl[4]), .i_pnl_alarm_ack(ack),
    .i_gui_auto(gui_auto), .i_gui_override(ovr), .i_gui_lamp_test(gui[0]),
    .i_gui_ctrl_en(gui[1]), .i_gui_manual(gui[2]), .i_gui_xfer_test(gui[3]),
    .i_gui_fault_reset(gui[4]), .i_cfg_pickup_pct(pickup), .i_cfg_stab_s(stab),
    .i_cfg_uf_hz(uf_hz), .i_cfg_freq_trip_en(trip_en), .i_cfg_alarm_dis(alarm_dis),
    .i_cfg_air_cooled(air_cooled), .i_norm_ok(norm_ok), .i_alt_ok(alt_ok), .i_norm_uf(norm_uf),
    .i_alt_uf(alt_uf), .i_out_of_phase(oop), .i_air_loss(air), .i_diag_fault(diag),
    .i_sw_fail_norm(fail_norm), .i_sw_fail_alt(fail_alt), .o_drv_norm(drv_n), .o_drv_alt(drv_a),
    .o_lamp_load(lamps[0]), .o_lamp_norm(lamps[1]), .o_lamp_alt(lamps[2]),
    .o_lamp_auto(lamps[3]), .o_lamp_manual(lamps[4]), .o_lamp_fault(lamps[5]),
    .o_lamp_pref_norm(lamps[6]), .o_lamp_pref_alt(lamps[7]), .o_lamp_phase(lamps[8]),
    .o_lamp_air_part(lamps[9]), .o_lamp_air_full(lamps[10]), .o_alarm(alarm),
    .o_disp_fault(disp_fault), .o_display(display), .o_pickup_pct(pick_o), .o_xfer_busy(busy));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [6:0] exp_pick(input logic [6:0] p);
    return (p < PICKUP_MIN_PCT) ? PICKUP_MIN_PCT : (p > PICKUP_MAX_PCT) ? PICKUP_MAX_PCT : p;
  endfunction : exp_pick

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // Exactly one driver on, on the expected side
  task automatic src(input logic to_alt);
    chk("drivers", {14'h0, to_alt, !to_alt}, {14'h0, drv_a, drv_n});
  endtask : src

  task automatic summarize;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    #400000;
    num_errors++;
    summarize();
  end

  initial
  begin
    seed = 68134; num_errors = 0; checks = 0; cnt = 16'h0;
    rst = 1'b1; auto = 1'b0; pref_alt = 1'b0; ack = 1'b0; ovr = 1'b0; gui_auto = 1'b0;
    alarm_dis = 1'b0; norm_ok = 1'b1; alt_ok = 1'b1; norm_uf = 1'b0; oop = 1'b0;
    fail_alt = 1'b0; stab = 4'h1; pickup = 7'h5a; air = 2'h0; diag = 8'h00;
    ce = 1'b1; uf_hz = 2'h2; trip_en = 1'b1; air_cooled = 1'b1; alt_uf = 1'b0; fail_norm = 1'b0;
    wt(3);
    rst = 1'b0;
    chk("display", 16'h0, display);
    wt(6);
    src(1'b0);
    for (int k = 0; k < 12; k++)
    begin
      pickup = (k < 4) ? corner[k] : 7'($random(seed));
      wt(1);
      chk("pickup", 16'(exp_pick(pickup)), 16'(pick_o));
    end
    $display("test pickup done");
    norm_ok = 1'b0;
    wt(20);
    src(1'b0);
    norm_ok = 1'b1;
    alt_ok = 1'b0;
    pm.push(1'b0, 5'h04); src(1'b0);
    pm.push(1'b0, 5'h06); src(1'b1);
    alt_ok = 1'b1;
    pm.push(1'b1, 5'h06); src(1'b0);
    cnt = cnt + 16'h2;
    chk("count", cnt, display);
    chk("lamp_manual", 16'h1, 16'(lamps[4]));
    $display("test manual done");
    auto = 1'b1; norm_ok = 1'b0;
    wt(20); src(1'b1);
    norm_ok = 1'b1;
    wt(5); src(1'b1);
    wt(30); src(1'b0);
    norm_uf = 1'b1; trip_en = 1'b0;
    wt(20); src(1'b0);
    trip_en = 1'b1;
    wt(20); src(1'b1);
    norm_uf = 1'b0;
    wt(40); src(1'b0);
    stab = 4'h4;
    pm.push(1'b0, 5'h08); src(1'b0);
    pm.push(1'b0, 5'h0a); src(1'b1);
    pref_alt = 1'b1;
    wt(60); src(1'b1);
    chk("lamp_pref_alt", 16'h1, 16'(lamps[7]));
    pref_alt = 1'b0;
    wt(60); src(1'b0);
    stab = 4'h1;
    cnt = cnt + 16'h6;
    chk("count", cnt, display);
    $display("test auto done");
    diag = 8'h01; wt(1); diag = 8'h00;
    wt(10);
    chk("alarm", 16'h0, 16'(alarm));
    diag = (8'($random(seed)) & 8'h7f) | 8'h01;
    wt(8);
    chk("alarm", 16'h1, 16'(alarm));
    chk("lamp_fault", 16'h1, 16'(lamps[5]));
    chk("disp_fault", 16'h1, 16'(disp_fault));
    ack = 1'b1;
    wt(6);
    chk("alarm", 16'h0, 16'(alarm));
    chk("lamp_fault", 16'h1, 16'(lamps[5]));
    ack = 1'b0; diag = diag | 8'h80;
    wt(8);
    chk("alarm", 16'h1, 16'(alarm));
    ack = 1'b1; wt(6); ack = 1'b0; diag = 8'h00;
    pm.push(1'b0, 5'h10); chk("lamp_fault", 16'h1, 16'(lamps[5]));
    pm.push(1'b0, 5'h12); chk("lamp_fault", 16'h0, 16'(lamps[5]));
    chk("count", cnt, display);
    alt_ok = 1'b0;
    pm.push(1'b1, 5'h12); chk("lamp_alt", 16'h0, 16'(lamps[2]));
    alt_ok = 1'b1; alarm_dis = 1'b1; diag = 8'h10;
    wt(8);
    chk("alarm", 16'h0, 16'(alarm));
    chk("lamp_fault", 16'h1, 16'(lamps[5]));
    diag = 8'h00;
    pm.push(1'b0, 5'h12);
    alarm_dis = 1'b0;
    $display("test faults done");
    fail_alt = 1'b1;
    wt(20); src(1'b1);
    fail_alt = 1'b0; oop = 1'b1; air = 2'h1;
    wt(6);
    chk("lamp_phase", 16'h1, 16'(lamps[8]));
    chk("lamp_fault", 16'h0, 16'(lamps[5]));
    chk("lamp_air_part", 16'h1, 16'(lamps[9]));
    air = 2'h3;
    wt(6);
    chk("lamp_air_full", 16'h1, 16'(lamps[10]));
    air_cooled = 1'b0;
    wt(6);
    chk("lamp_air_full", 16'h0, 16'(lamps[10]));
    air_cooled = 1'b1; oop = 1'b0; air = 2'h0; ovr = 1'b1;
    wt(6);
    chk("lamp_manual", 16'h1, 16'(lamps[4]));
    ovr = 1'b0;
    wt(40);
    fork
      pm.push(1'b1, 5'h01);
      begin
        wt(12);
        chk("lamps", 16'h07ff, 16'(lamps));
        src(1'b0);
      end
    join
    wt(40);
    chk("lamp_manual", 16'h0, 16'(lamps[4]));
    // Clock enable low freezes every register (the pickup clamp still follows live), even a lost source
    ce = 1'b0; norm_ok = 1'b0;
    wt(20);
    src(1'b0);
    chk("lamp_norm", 16'h1, 16'(lamps[1]));
    norm_ok = 1'b1; ce = 1'b1;
    $display("test indicators done");
    summarize();
  end
endmodule : test_bus_transfer_panel_control
